// ===== mpsc_module.sv
// Module end: power key, reset, sleep, airplane and wake signalling
// How it works
// (R1) Sleep via UART: enable, raise terminal ready
// (R2) Terminal ready low wakes the module
// (R3) Pending report while asleep raises ring indicator
// (R4) USB sleep: enable, terminal ready high, suspend
// (R5) Pending report on suspended bus: remote wake
// (R6) Host data over USB ends sleep
// (R7) Without remote wake, host wakes on ring
// (R8) Bus power removed allows sleep; restored wakes
// (R9) Radio-disable pin low selects airplane mode
// (R10) Levels 0 minimum, 1 full, 4 airplane
// (R11) Airplane mode: radio off, radio commands refused
// (R12) Radio-disable pin ignored until configured
// (R13) On: key low 500 ms, until status high
// (R14) Supply stable 300 ms before key press
// (R15) Off: key low 800 ms, off on release
// (R16) Keep key high after power-down command
// (R17) Reset line low 250 to 600 ms reboots
// (R18) Reset line only as a fallback
// (R19) Supply never cut while running
// (R20) Power-down command equals key off sequence
// (R21) Host times pulses with its own counter
`timescale 1ns/1ps
`include "mpsc_map.svh"
module mpsc_module
	import mpsc_pkg::*;
#(
	parameter int unsigned ON_CYC   = `MPSC_ON_KEY_MS * `MPSC_CYC_PER_MS,
	parameter int unsigned OFF_CYC  = `MPSC_OFF_KEY_MS * `MPSC_CYC_PER_MS,
	parameter int unsigned RST_CYC  = `MPSC_RST_MIN_MS * `MPSC_CYC_PER_MS,
	parameter int unsigned BOOT_CYC = `MPSC_BOOT_MS * `MPSC_CYC_PER_MS
) (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	mpsc_if.dev             pins,
	input  wire logic       cmd_valid_i,
	input  wire mpsc_cmd_t  cmd_i,
	input  wire logic [7:0] cmd_arg_i,
	input  wire logic       urc_pending_i,
	input  wire logic       host_rwake_cap_i,
	output logic            cmd_ok_o,
	output logic            cmd_err_o,
	output logic            powered_o,
	output logic            asleep_o,
	output logic            radio_on_o,
	output logic            sim_on_o,
	output logic            airplane_o
);
	typedef enum logic [1:0] {OFF, BOOT, ON, SHUTDOWN} mpsc_pwr_t;

	mpsc_pwr_t   pwr;
	logic [31:0] key_cnt;
	logic [31:0] rst_cnt;
	logic [31:0] boot_cnt;
	logic        key_long_on;
	logic        key_long_off;
	logic        key_armed;
	logic        sleep_en;
	logic        air_pin_en;
	logic [7:0]  fun;
	logic        asleep;
	logic        ring;
	logic        rwake;
	logic        vbus_q;

	wire key_low      = ~pins.power_key_line;
	wire rst_low      = ~pins.reset_line_n;
	wire rst_fire     = pins.reset_line_n && rst_cnt >= RST_CYC;
	wire is_on        = (pwr == ON);
	wire pin_air      = air_pin_en && !pins.radio_disable_n;
	wire air_mode     = is_on && (fun == `MPSC_FUN_AIR || pin_air);
	wire radio_ok     = is_on && fun == `MPSC_FUN_FULL && !pin_air;
	// Terminal ready alone allows sleep, so a serial-only host needs no bus steps
	wire sleep_ready  = pins.terminal_ready;
	// Bus power wakes only on its return; a steady powered bus must not
	wire vbus_back    = pins.usb_bus_power_detect && !vbus_q;
	wire wake_evt     = !pins.terminal_ready || pins.usb_host_data || vbus_back;
	wire cmd_take     = cmd_valid_i && is_on && !asleep;
	wire radio_refuse = cmd_i == MPSC_CMD_RADIO && !radio_ok;
	wire pd_cmd       = cmd_take && cmd_i == MPSC_CMD_POWER_DOWN;
	wire fun_legal    = cmd_arg_i == `MPSC_FUN_MIN || cmd_arg_i == `MPSC_FUN_FULL ||
		cmd_arg_i == `MPSC_FUN_AIR;

	// ----------------------------------------
	// Power key timing and reset pulse
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			key_cnt <= '0;
			rst_cnt <= '0;
		end else begin
			key_cnt <= key_low ? (key_cnt == 32'hFFFF_FFFF ? key_cnt : key_cnt + 32'h0000_0001) : '0;
			rst_cnt <= rst_low ? (rst_cnt == 32'hFFFF_FFFF ? rst_cnt : rst_cnt + 32'h0000_0001) : '0;
		end
	end
	assign key_long_on  = key_cnt >= ON_CYC;
	assign key_long_off = key_cnt >= OFF_CYC;

	// ----------------------------------------
	// Power state
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pwr       <= OFF;
			boot_cnt  <= '0;
			key_armed <= 1'b0;
		end else if (rst_fire && pwr != OFF) begin
			pwr      <= BOOT; // (R17)
			boot_cnt <= '0;
		end else begin
			unique case (pwr)
				OFF: begin
					// A press of ON_CYC re-powers the part; a key held low since a command shutdown keeps it in SHUTDOWN
					if (key_long_on) begin
						pwr      <= BOOT; // (R13) (R16)
						boot_cnt <= '0;
					end
				end
				BOOT: begin
					boot_cnt <= boot_cnt + 32'h0000_0001;
					if (boot_cnt >= BOOT_CYC) begin
						pwr       <= ON;
						key_armed <= !key_low;
					end
				end
				ON: begin
					// The key that switched us on must be released before it counts again
					if (!key_low)
						key_armed <= 1'b1;
					if (pd_cmd)
						pwr <= SHUTDOWN; // (R20)
					else if (key_armed && key_long_off)
						pwr <= SHUTDOWN; // (R15)
				end
				SHUTDOWN: begin
					// Off only after the key is released
					if (!key_low)
						pwr <= OFF; // (R15)
				end
			endcase
		end
	end

	// ----------------------------------------
	// Commands, functionality level, sleep
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sleep_en   <= 1'b0;
			air_pin_en <= 1'b0; // (R12)
			fun        <= `MPSC_FUN_FULL; // (R10)
			cmd_ok_o   <= 1'b0;
			cmd_err_o  <= 1'b0;
		end else begin
			cmd_ok_o  <= 1'b0;
			cmd_err_o <= 1'b0;
			if (pwr != ON) begin
				sleep_en   <= 1'b0;
				air_pin_en <= 1'b0;
				fun        <= `MPSC_FUN_FULL;
			end else if (cmd_take) begin
				unique case (cmd_i)
					MPSC_CMD_SLEEP_EN: begin
						sleep_en <= cmd_arg_i[0];
						cmd_ok_o <= 1'b1;
					end
					MPSC_CMD_FUN: begin
						if (fun_legal)
							fun <= cmd_arg_i; // (R10)
						cmd_ok_o  <= fun_legal;
						cmd_err_o <= !fun_legal;
					end
					MPSC_CMD_AIR_CFG: begin
						air_pin_en <= cmd_arg_i[0]; // (R12)
						cmd_ok_o   <= 1'b1;
					end
					MPSC_CMD_RADIO: begin
						cmd_ok_o  <= !radio_refuse;
						cmd_err_o <= radio_refuse; // (R11)
					end
					default: begin
						cmd_ok_o <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			asleep <= 1'b0;
			ring   <= 1'b0;
			rwake  <= 1'b0;
			// Host idles with the bus powered, so no false return follows reset
			vbus_q <= 1'b1;
		end else begin
			vbus_q <= pins.usb_bus_power_detect;
			if (!is_on)
				asleep <= 1'b0;
			else if (asleep && wake_evt)
				asleep <= 1'b0; // (R2) (R6) (R8)
			else if (sleep_en && sleep_ready)
				asleep <= 1'b1; // (R1) (R4) (R8)
			// Ring while the module is asleep or the bus is suspended and a report waits
			ring  <= is_on && urc_pending_i && (asleep || pins.usb_suspend); // (R3) (R7)
			rwake <= is_on && urc_pending_i && pins.usb_suspend && host_rwake_cap_i; // (R5)
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pins.status     <= 1'b0;
			pins.ring_ind   <= 1'b0;
			pins.usb_remote_wake <= 1'b0;
			powered_o  <= 1'b0;
			asleep_o   <= 1'b0;
			radio_on_o <= 1'b0;
			sim_on_o   <= 1'b0;
			airplane_o <= 1'b0;
		end else begin
			pins.status     <= is_on;
			pins.ring_ind   <= ring;
			pins.usb_remote_wake <= rwake;
			powered_o  <= pwr != OFF;
			asleep_o   <= asleep;
			radio_on_o <= radio_ok; // (R11)
			sim_on_o   <= is_on && fun != `MPSC_FUN_MIN;
			airplane_o <= air_mode; // (R9)
		end
	end
endmodule

// ===== mpsc_map.svh
// Timing constants and fixed values for the module power and sleep control link
`ifndef MPSC_MAP_SVH
`define MPSC_MAP_SVH
`define MPSC_CLK_MHZ          100
`define MPSC_ON_KEY_MS        500
`define MPSC_VBAT_STABLE_MS   300
`define MPSC_OFF_KEY_MS       800
`define MPSC_RST_MIN_MS       250
`define MPSC_RST_MAX_MS       600
`define MPSC_RST_PULSE_MS     400
`define MPSC_BOOT_MS          100
`define MPSC_CYC_PER_MS       (`MPSC_CLK_MHZ * 1000)
`define MPSC_FUN_MIN          8'h00
`define MPSC_FUN_FULL         8'h01
`define MPSC_FUN_AIR          8'h04
`endif

// ===== mpsc_pkg.sv
// Types shared by both ends of the module power and sleep control link
package mpsc_pkg;
	typedef enum logic [2:0] {
		MPSC_CMD_NONE,
		MPSC_CMD_SLEEP_EN,
		MPSC_CMD_FUN,
		MPSC_CMD_POWER_DOWN,
		MPSC_CMD_AIR_CFG,
		MPSC_CMD_RADIO
	} mpsc_cmd_t;
	typedef enum logic [2:0] {
		MPSC_OP_NONE,
		MPSC_OP_POWER_ON,
		MPSC_OP_POWER_OFF,
		MPSC_OP_RESET,
		MPSC_OP_SLEEP_UART,
		MPSC_OP_SLEEP_USB,
		MPSC_OP_SLEEP_VBUS,
		MPSC_OP_WAKE
	} mpsc_op_t;
endpackage

// ===== mpsc_if.sv
// Pin-level link between the cellular module and its host controller
`timescale 1ns/1ps
interface mpsc_if;
	logic power_key_line;
	logic reset_line_n;
	logic terminal_ready;
	logic usb_bus_power_detect;
	logic usb_suspend;
	logic usb_host_data;
	logic radio_disable_n;
	logic status;
	logic ring_ind;
	logic usb_remote_wake;
	modport dev (
		input  power_key_line,
		input  reset_line_n,
		input  terminal_ready,
		input  usb_bus_power_detect,
		input  usb_suspend,
		input  usb_host_data,
		input  radio_disable_n,
		output status,
		output ring_ind,
		output usb_remote_wake
	);
	modport host (
		output power_key_line,
		output reset_line_n,
		output terminal_ready,
		output usb_bus_power_detect,
		output usb_suspend,
		output usb_host_data,
		output radio_disable_n,
		input  status,
		input  ring_ind,
		input  usb_remote_wake
	);
endinterface

// ===== mpsc_host.sv
// Host end: sequences power key, reset and sleep lines with its own timer
`timescale 1ns/1ps
`include "mpsc_map.svh"
module mpsc_host
	import mpsc_pkg::*;
#(
	parameter int unsigned ON_CYC   = `MPSC_ON_KEY_MS * `MPSC_CYC_PER_MS,
	parameter int unsigned OFF_CYC  = `MPSC_OFF_KEY_MS * `MPSC_CYC_PER_MS,
	parameter int unsigned VBAT_CYC = `MPSC_VBAT_STABLE_MS * `MPSC_CYC_PER_MS,
	parameter int unsigned RST_CYC  = `MPSC_RST_PULSE_MS * `MPSC_CYC_PER_MS
) (
	input  wire logic     clk_i,
	input  wire logic     rstn_i,
	mpsc_if.host          pins,
	input  wire logic     op_valid_i,
	input  wire mpsc_op_t op_i,
	input  wire logic     vbat_ok_i,
	input  wire logic     airplane_req_i,
	output logic          busy_o,
	output logic          done_o,
	output logic          module_on_o,
	output logic          wake_req_o
);
	typedef enum logic [2:0] {IDLE, VBAT_WAIT, KEY_ON, KEY_OFF, RST_PULSE} mpsc_hst_t;

	mpsc_hst_t   st;
	logic [31:0] cnt;
	logic [31:0] vbat_cnt;
	wire vbat_stable = vbat_cnt >= VBAT_CYC;
	wire cnt_top     = cnt == 32'hFFFF_FFFF;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			vbat_cnt <= '0;
		else
			vbat_cnt <= !vbat_ok_i ? '0 : (vbat_stable ? vbat_cnt : vbat_cnt + 32'h0000_0001); // (R14)
	end

	// Supply is never cut here; RESET is a fallback issued only on request
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st <= IDLE;
			cnt <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			pins.power_key_line <= 1'b1; // (R16)
			pins.reset_line_n   <= 1'b1;
			pins.terminal_ready <= 1'b0;
			pins.usb_bus_power_detect <= 1'b1;
			pins.usb_suspend    <= 1'b0;
			pins.usb_host_data  <= 1'b0;
			pins.radio_disable_n <= 1'b1; // (R9)
		end else begin
			done_o <= 1'b0;
			pins.usb_host_data <= 1'b0;
			pins.radio_disable_n <= !airplane_req_i; // (R9)
			cnt <= cnt_top ? cnt : cnt + 32'h0000_0001; // (R21)
			unique case (st)
				IDLE: begin
					busy_o <= 1'b0;
					if (op_valid_i) begin
						cnt <= '0;
						busy_o <= op_i inside {MPSC_OP_POWER_ON, MPSC_OP_POWER_OFF, MPSC_OP_RESET};
						done_o <= !(op_i inside {MPSC_OP_POWER_ON, MPSC_OP_POWER_OFF,
							MPSC_OP_RESET});
						unique case (op_i)
							MPSC_OP_POWER_ON:  st <= VBAT_WAIT;
							MPSC_OP_POWER_OFF: begin
								st <= KEY_OFF;
								pins.power_key_line <= 1'b0; // (R15)
							end
							MPSC_OP_RESET: begin
								st <= RST_PULSE;
								pins.reset_line_n <= 1'b0; // (R17) (R18)
							end
							// Sleep entry: command is issued beforehand by software
							MPSC_OP_SLEEP_UART: pins.terminal_ready <= 1'b1; // (R1)
							MPSC_OP_SLEEP_USB: begin
								pins.terminal_ready <= 1'b1;
								pins.usb_suspend    <= 1'b1; // (R4) (R7)
							end
							MPSC_OP_SLEEP_VBUS: begin
								pins.terminal_ready <= 1'b1;
								pins.usb_bus_power_detect <= 1'b0; // (R8)
							end
							MPSC_OP_WAKE: begin
								pins.terminal_ready <= 1'b0; // (R2)
								pins.usb_suspend    <= 1'b0;
								pins.usb_bus_power_detect <= 1'b1; // (R8)
								pins.usb_host_data  <= 1'b1; // (R6)
							end
							default: ;
						endcase
					end
				end
				VBAT_WAIT: begin
					if (vbat_stable) begin
						st <= KEY_ON;
						cnt <= '0;
						pins.power_key_line <= 1'b0; // (R13) (R14)
					end
				end
				KEY_ON: begin
					if (cnt >= ON_CYC && pins.status) begin
						st <= IDLE;
						done_o <= 1'b1;
						pins.power_key_line <= 1'b1; // (R13)
					end
				end
				KEY_OFF: begin
					if (cnt >= OFF_CYC) begin
						st <= IDLE;
						done_o <= 1'b1;
						pins.power_key_line <= 1'b1; // (R15)
					end
				end
				RST_PULSE: begin
					if (cnt >= RST_CYC) begin
						st <= IDLE;
						done_o <= 1'b1;
						pins.reset_line_n <= 1'b1; // (R17)
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			module_on_o <= 1'b0;
			wake_req_o  <= 1'b0;
		end else begin
			module_on_o <= pins.status;
			wake_req_o  <= pins.ring_ind || pins.usb_remote_wake; // (R3) (R5) (R7)
		end
	end
endmodule

// ===== mpsc_asserts.sv
// Concurrent checks on the pins between the module end and the host end
`timescale 1ns/1ps
module mpsc_asserts #(
	parameter int ON_CYC  = 20,
	parameter int OFF_CYC = 30,
	parameter int RST_CYC = 10
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic power_key_line,
	input wire logic reset_line_n,
	input wire logic terminal_ready,
	input wire logic usb_suspend,
	input wire logic status,
	input wire logic ring_ind,
	input wire logic usb_remote_wake
);
	// ----------------------------------------
	// Pulse width counters
	// ----------------------------------------
	int unsigned key_cnt;
	int unsigned rst_cnt;
	logic        st_fall;
	// Status frozen at the start of a key press tells an on press from an off press
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			key_cnt <= 0;
			rst_cnt <= 0;
			st_fall <= 1'h0;
		end else begin
			key_cnt <= power_key_line ? 0 : key_cnt + 1;
			rst_cnt <= reset_line_n ? 0 : rst_cnt + 1;
			if (power_key_line) begin
				st_fall <= status;
			end
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	a_on_press_width: assert property ($rose(power_key_line) && !st_fall |-> key_cnt >= ON_CYC)
		else $error("power key on press too short");
	a_on_release_late: assert property ($rose(power_key_line) && !st_fall |-> $past(status))
		else $error("power key released before status high");
	a_off_press_width: assert property ($rose(power_key_line) && st_fall |-> key_cnt >= OFF_CYC)
		else $error("power key off press too short");
	a_off_after_release: assert property ($rose(power_key_line) && st_fall |-> ##[1:8] !status)
		else $error("module still on after off press");
	a_reset_width: assert property ($rose(reset_line_n) |-> rst_cnt >= RST_CYC)
		else $error("reset pulse too short");
	a_reset_reboot: assert property ($rose(reset_line_n) |-> ##[1:3] !status ##[1:20] status)
		else $error("no status after reset pulse");
	a_dtr_wakes: assert property ($fell(terminal_ready) && !usb_suspend |-> ##[1:4] !ring_ind)
		else $error("ring stays up after wake");
	a_ring_cause: assert property (ring_ind |-> $past(terminal_ready, 2) ||
		$past(terminal_ready, 3) || $past(usb_suspend, 2))
		else $error("ring without sleep or suspend");
	a_rwake_suspend: assert property (usb_remote_wake |-> $past(usb_suspend, 2))
		else $error("remote wake on a live bus");
	c_ring: cover property ($rose(ring_ind));
	c_rwake: cover property ($rose(usb_remote_wake));
	c_off: cover property ($fell(status));
endmodule

// ===== testbench.sv
// Self-checking bench joining the module end to the host end
`timescale 1ns/1ps
module testbench;
	import mpsc_pkg::*;
	logic       clk_i = 1'h0;
	logic       rstn_i = 1'h0;
	logic       cmd_valid = 1'h0;
	mpsc_cmd_t  cmd = MPSC_CMD_NONE;
	logic [7:0] arg = 8'h00;
	logic       urc = 1'h0;
	logic       rwcap = 1'h0;
	logic       op_valid = 1'h0;
	mpsc_op_t   op = MPSC_OP_NONE;
	logic       vbat = 1'h0;
	logic       air = 1'h0;
	logic       ok, er, pwr, slp, rad, sim, apl, busy, done, mon, wreq;
	logic [1:0] exp_q[$];
	int         err_count = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	// Shortened timing so each sequence fits a short run; host reset outlasts the module minimum
	localparam int unsigned ON_T   = 20;
	localparam int unsigned OFF_T  = 30;
	localparam int unsigned MRST_T = 10;
	localparam int unsigned BOOT_T = 5;
	localparam int unsigned VBAT_T = 8;
	localparam int unsigned HRST_T = 15;
	mpsc_if bus();
	mpsc_module #(.ON_CYC(ON_T), .OFF_CYC(OFF_T), .RST_CYC(MRST_T), .BOOT_CYC(BOOT_T)) i_mpsc_module (
		.clk_i(clk_i), .rstn_i(rstn_i), .pins(bus), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
		.cmd_arg_i(arg), .urc_pending_i(urc), .host_rwake_cap_i(rwcap), .cmd_ok_o(ok),
		.cmd_err_o(er), .powered_o(pwr), .asleep_o(slp), .radio_on_o(rad), .sim_on_o(sim),
		.airplane_o(apl));
	mpsc_host #(.ON_CYC(ON_T), .OFF_CYC(OFF_T), .VBAT_CYC(VBAT_T), .RST_CYC(HRST_T)) i_mpsc_host (
		.clk_i(clk_i), .rstn_i(rstn_i), .pins(bus), .op_valid_i(op_valid), .op_i(op),
		.vbat_ok_i(vbat), .airplane_req_i(air), .busy_o(busy), .done_o(done),
		.module_on_o(mon), .wake_req_o(wreq));
	mpsc_asserts #(.ON_CYC(ON_T), .OFF_CYC(OFF_T), .RST_CYC(MRST_T)) i_mpsc_asserts (
		.clk_i(clk_i), .rstn_i(rstn_i), .power_key_line(bus.power_key_line),
		.reset_line_n(bus.reset_line_n), .terminal_ready(bus.terminal_ready),
		.usb_suspend(bus.usb_suspend), .status(bus.status), .ring_ind(bus.ring_ind),
		.usb_remote_wake(bus.usb_remote_wake));
	// ----------------------------------------
	// Clock, timeout, verdict
	// ----------------------------------------
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic results();
		$display("checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end
	task automatic fail(input string s);
		err_count++;
		$display("unexpected at %0t: %s", $time, s);
	endtask
	// Answers are compared at the falling edge, once they have settled
	always @(negedge clk_i) begin
		if (ok === 1'h1 || er === 1'h1) begin
			samples_checked++;
			if (exp_q.size() == 0) begin
				fail("answer with none pending");
			end else if (exp_q.pop_front() !== {ok, er}) begin
				fail("wrong command answer");
			end
		end
	end
	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic chk(input logic got, input logic want);
		@(negedge clk_i);
		samples_checked++;
		if (got !== want) begin
			fail("level mismatch");
		end
	endtask
	// Level is taken at the call, so every driver task returns on a falling edge
	// e is the expected {ok, err}; 0 means the module must stay silent
	task automatic send(input mpsc_cmd_t c, input logic [7:0] a, input logic [1:0] e);
		if (e != 2'h0) begin
			exp_q.push_back(e);
		end
		@(posedge clk_i);
		cmd_valid <= 1'h1;
		cmd <= c;
		arg <= a;
		@(posedge clk_i);
		cmd_valid <= 1'h0;
		repeat (3) @(negedge clk_i);
	endtask
	task automatic host(input mpsc_op_t o);
		int   n;
		logic lng;
		n = 0;
		lng = o inside {MPSC_OP_POWER_ON, MPSC_OP_POWER_OFF, MPSC_OP_RESET};
		@(posedge clk_i);
		op_valid <= 1'h1;
		op <= o;
		@(posedge clk_i);
		op_valid <= 1'h0;
		do begin
			@(negedge clk_i);
			n++;
			if (n == 1) begin
				samples_checked++;
				if (busy !== lng) begin
					fail("host busy level wrong");
				end
			end
		end while (done !== 1'h1 && n < 500);
		if (n == 500) begin
			fail("host op never done");
		end
		repeat (5) @(negedge clk_i);
	endtask
	task automatic drive(input logic u, input logic w, input logic p);
		@(posedge clk_i);
		urc <= u;
		rwcap <= w;
		air <= p;
		repeat (4) @(negedge clk_i);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(51946));
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'h1;
		vbat <= 1'h1;
		host(MPSC_OP_POWER_ON);
		chk(pwr, 1'h1);
		chk(mon, 1'h1);
		send(MPSC_CMD_FUN, 8'h00, 2'h2);
		chk(sim, 1'h0);
		chk(rad, 1'h0);
		send(MPSC_CMD_FUN, 8'h04, 2'h2);
		chk(apl, 1'h1);
		send(MPSC_CMD_RADIO, 8'h00, 2'h1);
		send(MPSC_CMD_FUN, 8'h05 + 8'($urandom % 200), 2'h1);
		send(MPSC_CMD_FUN, 8'h01, 2'h2);
		chk(rad, 1'h1);
		chk(sim, 1'h1);
		drive(1'h0, 1'h0, 1'h1);
		send(MPSC_CMD_RADIO, 8'h00, 2'h2);
		send(MPSC_CMD_AIR_CFG, 8'h01, 2'h2);
		send(MPSC_CMD_RADIO, 8'h00, 2'h1);
		chk(apl, 1'h1);
		drive(1'h0, 1'h0, 1'h0);
		send(MPSC_CMD_RADIO, 8'h00, 2'h2);
		send(MPSC_CMD_SLEEP_EN, 8'h01, 2'h2);
		host(MPSC_OP_SLEEP_UART);
		chk(slp, 1'h1);
		send(MPSC_CMD_FUN, 8'h01, 2'h0);
		drive(1'h1, 1'h0, 1'h0);
		chk(bus.ring_ind, 1'h1);
		chk(wreq, 1'h1);
		host(MPSC_OP_WAKE);
		chk(slp, 1'h0);
		drive(1'h1, 1'h1, 1'h0);
		host(MPSC_OP_SLEEP_USB);
		chk(slp, 1'h1);
		chk(bus.usb_remote_wake, 1'h1);
		drive(1'h1, 1'h0, 1'h0);
		chk(bus.usb_remote_wake, 1'h0);
		chk(bus.ring_ind, 1'h1);
		host(MPSC_OP_WAKE);
		chk(slp, 1'h0);
		drive(1'h0, 1'h0, 1'h0);
		host(MPSC_OP_SLEEP_VBUS);
		chk(slp, 1'h1);
		chk(bus.usb_bus_power_detect, 1'h0);
		host(MPSC_OP_WAKE);
		chk(slp, 1'h0);
		send(MPSC_CMD_SLEEP_EN, 8'h00, 2'h2);
		host(MPSC_OP_SLEEP_UART);
		chk(slp, 1'h0);
		host(MPSC_OP_WAKE);
		host(MPSC_OP_RESET);
		chk(mon, 1'h0);
		repeat (20) @(negedge clk_i);
		chk(pwr, 1'h1);
		chk(mon, 1'h1);
		send(MPSC_CMD_POWER_DOWN, 8'h00, 2'h2);
		repeat (8) @(negedge clk_i);
		chk(pwr, 1'h0);
		host(MPSC_OP_POWER_ON);
		host(MPSC_OP_POWER_OFF);
		repeat (8) @(negedge clk_i);
		chk(pwr, 1'h0);
		chk(mon, 1'h0);
		results();
	end
endmodule
